//--- verilog/ccsu_pkg.sv
// Package for the common command and status unit: command codes, slot
// geometry, status byte layout, error codes and timing constants.
// Assumes a 250 MHz system clock.
package ccsu_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_MHZ         = 250;
   localparam int unsigned SELFTEST_MS     = 2;      // "a few seconds" scaled as a parameter default
   localparam int unsigned SELFTEST_CYCLES = SELFTEST_MS * 1000 * CLK_MHZ;

   // ------------------------------------------------------------------
   // Configuration slots
   // ------------------------------------------------------------------
   localparam int unsigned CFG_W      = 32;
   localparam int unsigned SLOT_NUM   = 17;
   localparam int unsigned SLOT_W     = 5;
   localparam logic [4:0]  SLOT_MAX   = 5'h10;
   localparam logic [4:0]  SLOT_PDOWN = 5'h00;
   localparam logic [31:0] CFG_FACTORY = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Commands
   // ------------------------------------------------------------------
   localparam logic [3:0] CMD_SAVE      = 4'h1;
   localparam logic [3:0] CMD_RECALL    = 4'h2;
   localparam logic [3:0] CMD_SRE_WR    = 4'h3;
   localparam logic [3:0] CMD_SRE_RD    = 4'h4;
   localparam logic [3:0] CMD_STB_RD    = 4'h5;
   localparam logic [3:0] CMD_CLS       = 4'h6;
   localparam logic [3:0] CMD_RST       = 4'h7;
   localparam logic [3:0] CMD_SYS_PRE   = 4'h8;
   localparam logic [3:0] CMD_STAT_PRE  = 4'h9;
   localparam logic [3:0] CMD_TRG       = 4'ha;
   localparam logic [3:0] CMD_INIT      = 4'hb;
   localparam logic [3:0] CMD_TST       = 4'hc;
   localparam logic [3:0] CMD_WAI       = 4'hd;
   localparam logic [3:0] CMD_ERR_RD    = 4'he;
   localparam logic [3:0] CMD_PSC_WR    = 4'hf;

   // ------------------------------------------------------------------
   // Status byte bit positions
   // ------------------------------------------------------------------
   localparam int unsigned STB_ERRQ = 2;
   localparam int unsigned STB_QUES = 3;
   localparam int unsigned STB_MAV  = 4;
   localparam int unsigned STB_ESB  = 5;
   localparam int unsigned STB_OPER = 7;
   localparam logic [7:0]  STB_RESET = 8'h00;
   localparam logic [7:0]  SRE_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Error queue
   // ------------------------------------------------------------------
   localparam int unsigned  ERRQ_DEPTH    = 20;
   localparam logic [15:0]  ERR_NONE      = 16'h0000;
   localparam logic [15:0]  ERR_OVERFLOW  = 16'hfea2;   // -350
   localparam logic [15:0]  ERR_SELFTEST  = 16'h0276;   // 630
   localparam logic [15:0]  ERR_TRG_IGN   = 16'hff2d;   // -211
   localparam logic [15:0]  ERR_RANGE     = 16'hff22;   // -222
   localparam logic [15:0]  ERR_RCL_EMPTY = 16'hff1f;   // -225 chosen for empty slot

   // ------------------------------------------------------------------
   // Answer codes
   // ------------------------------------------------------------------
   localparam logic [15:0] ANS_PASS = 16'h0000;
   localparam logic [15:0] ANS_FAIL = 16'h0001;

endpackage : ccsu_pkg

//--- verilog/ccsu_slot_if.sv
// Interface between the command unit and its slot memory.
// Assumes one clock shared by both modules.
`timescale 1ns/1ns
interface ccsu_slot_if;
   logic        wr_en;
   logic [4:0]  wr_slot;
   logic [31:0] wr_data;
   logic [4:0]  rd_slot;
   logic [31:0] rd_data;
   logic        rd_full;

   modport ctrl (output wr_en, output wr_slot, output wr_data, output rd_slot,
                 input rd_data, input rd_full);
   modport mem  (input wr_en, input wr_slot, input wr_data, input rd_slot,
                 output rd_data, output rd_full);
endinterface : ccsu_slot_if

//--- verilog/ccsu_slot_mem.sv
// Seventeen configuration slots with a full flag per slot.
// Assumes the slots stand for nonvolatile storage: rstn clears only the
// full flags of slots 1..16; slot 0 has its flag set so power-down state lives.
`timescale 1ns/1ns
module ccsu_slot_mem (
   input wire logic clk,
   input wire logic rstn,
   ccsu_slot_if.mem slot
);

   logic [31:0] mem_q [ccsu_pkg::SLOT_NUM];
   logic [16:0] full_q;
   logic [16:0] full_d;
   logic [31:0] rd_q;
   logic        rdf_q;

   // ------------------------------------------------------------------
   // Full flags: a write marks its slot as holding a state
   // ------------------------------------------------------------------
   always_comb begin
      full_d = full_q;
      if (slot.wr_en) begin
         full_d[slot.wr_slot] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         full_q <= 17'h00001;
      end else begin
         full_q <= full_d;
      end
   end

   // Storage array and registered read; no reset on the data itself
   always_ff @(posedge clk) begin
      if (slot.wr_en) begin
         mem_q[slot.wr_slot] <= slot.wr_data;
      end
      rd_q  <= mem_q[slot.rd_slot];
      rdf_q <= full_q[slot.rd_slot];
   end

   assign slot.rd_data = rd_q;
   assign slot.rd_full = rdf_q;

endmodule : ccsu_slot_mem

//--- verilog/ccsu_top.sv
// Common command and status unit: saves configuration slots, keeps the
// status byte and its enable mask, gates bus triggers, runs self-test,
// holds commands for the wait command, and keeps the error queue.
// Assumes commands arrive as one-cycle strobes from a parser in the same
// clock domain; instrument conditions are asynchronous levels.
`timescale 1ns/1ns
module ccsu_top #(
   parameter int unsigned SELFTEST_CYCLES = ccsu_pkg::SELFTEST_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [7:0]  cmd_arg,
   output logic             cmd_ready,
   input  wire logic [31:0] cfg_live,
   output logic [31:0]      cfg_load,
   output logic             cfg_load_valid,
   input  wire logic        power_down,
   input  wire logic        ques_cond,
   input  wire logic        mav_cond,
   input  wire logic        esb_cond,
   input  wire logic        oper_cond,
   input  wire logic        ops_pending,
   input  wire logic        trig_src_bus,
   input  wire logic        selftest_fail,
   output logic [15:0]      ans_data,
   output logic             ans_valid,
   output logic             srq,
   output logic             trig_out,
   output logic             wait_trig
);

   // ------------------------------------------------------------------
   // Slot memory
   // ------------------------------------------------------------------
   ccsu_slot_if slot_bus ();

   ccsu_slot_mem u_mem (
      .clk  (clk),
      .rstn (rstn),
      .slot (slot_bus.mem)
   );

   // ------------------------------------------------------------------
   // Input synchronisers for asynchronous condition levels
   // ------------------------------------------------------------------
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;

   // Two flops per level; only the second stage is read by logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= {power_down, ques_cond, mav_cond, esb_cond, oper_cond, ops_pending};
         sync2_q <= sync1_q;
      end
   end

   logic pdown_s;
   logic pend_s;
   assign pdown_s = sync2_q[5];
   assign pend_s  = sync2_q[0];

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {CCSU_BOOT, CCSU_BOOT_RD, CCSU_IDLE, CCSU_RECALL,
                             CCSU_TEST, CCSU_WAIT, CCSU_DOWN} ccsu_state_e;

   ccsu_state_e state_q, state_d;
   logic [7:0]  sre_q, sre_d;
   logic        psc_q, psc_d;
   logic        pwr_rst_q, pwr_rst_d;
   logic        stb_clr_q, stb_clr_d;
   logic [7:0]  stb_q, stb_d;
   logic        srq_q, srq_d;
   logic        wtrig_q, wtrig_d;
   logic        trg_q, trg_d;
   logic [31:0] tcnt_q, tcnt_d;
   logic [4:0]  rslot_q, rslot_d;
   logic [15:0] ans_q, ans_d;
   logic        ansv_q, ansv_d;
   logic [31:0] cfgl_q, cfgl_d;
   logic        cfglv_q, cfglv_d;
   logic        pdone_q, pdone_d;
   logic [15:0] errq_q [ccsu_pkg::ERRQ_DEPTH];
   logic [15:0] errq_d [ccsu_pkg::ERRQ_DEPTH];
   logic [4:0]  ecnt_q, ecnt_d;
   logic        eovf_q, eovf_d;

   // Push one error code onto the queue image, honouring overflow policy
   function automatic void err_push(input logic [15:0] code);
      if (eovf_d) begin
         // Further errors are dropped until an error read or a clear frees a place
      end else if (ecnt_d == 5'(ccsu_pkg::ERRQ_DEPTH)) begin
         errq_d[ccsu_pkg::ERRQ_DEPTH-1] = ccsu_pkg::ERR_OVERFLOW;
         eovf_d = 1'b1;
      end else begin
         errq_d[ecnt_d] = code;
         ecnt_d = ecnt_d + 5'h01;
      end
   endfunction : err_push

   // Factory reset of configuration; slots and the enable mask are kept
   function automatic void factory_reset();
      cfgl_d    = ccsu_pkg::CFG_FACTORY;
      cfglv_d   = 1'b1;
      stb_clr_d = 1'b1;
      wtrig_d   = 1'b0;
   endfunction : factory_reset

   // ------------------------------------------------------------------
   // Next-state logic for command handling
   // ------------------------------------------------------------------
   always_comb begin
      state_d   = state_q;
      sre_d     = sre_q;
      psc_d     = psc_q;
      pwr_rst_d = pwr_rst_q;
      stb_clr_d = 1'b0;
      wtrig_d   = wtrig_q;
      trg_d     = 1'b0;
      tcnt_d    = tcnt_q;
      rslot_d   = rslot_q;
      ans_d     = ans_q;
      ansv_d    = 1'b0;
      cfgl_d    = cfgl_q;
      cfglv_d   = 1'b0;
      pdone_d   = pdone_q;
      errq_d    = errq_q;
      ecnt_d    = ecnt_q;
      eovf_d    = eovf_q;
      slot_bus.wr_en   = 1'b0;
      slot_bus.wr_slot = ccsu_pkg::SLOT_PDOWN;
      slot_bus.wr_data = cfg_live;
      // Read address held in a register so the slot stays put while the memory reads
      slot_bus.rd_slot = rslot_q;
      if (!pdown_s) begin
         pdone_d = 1'b0;
      end
      case (state_q)
         CCSU_BOOT: begin
            // Power-up: recall power-down state; rstn clears pwr_rst_q, so factory reset is never chosen here
            if (pwr_rst_q) begin
               factory_reset();
               state_d = CCSU_IDLE;
            end else begin
               state_d = CCSU_BOOT_RD;
            end
         end
         CCSU_BOOT_RD: begin
            state_d = CCSU_RECALL;
         end
         CCSU_RECALL: begin
            // Registered read data from the memory is valid now
            if (slot_bus.rd_full) begin
               cfgl_d  = slot_bus.rd_data;
               cfglv_d = 1'b1;
            end else begin
               err_push(ccsu_pkg::ERR_RCL_EMPTY);
            end
            state_d = CCSU_IDLE;
         end
         CCSU_TEST: begin
            if (tcnt_q == 32'(SELFTEST_CYCLES - 1)) begin
               ansv_d = 1'b1;
               if (selftest_fail) begin
                  ans_d = ccsu_pkg::ANS_FAIL;
                  err_push(ccsu_pkg::ERR_SELFTEST);
               end else begin
                  ans_d = ccsu_pkg::ANS_PASS;
               end
               factory_reset();
               state_d = CCSU_IDLE;
            end else begin
               tcnt_d = tcnt_q + 32'h1;
            end
         end
         CCSU_WAIT: begin
            // Later commands stall on cmd_ready until nothing is pending
            if (!pend_s) begin
               state_d = CCSU_IDLE;
            end
         end
         CCSU_DOWN: begin
            state_d = CCSU_IDLE;
         end
         default: begin
            if (pdown_s && !pdone_q) begin
               slot_bus.wr_en   = 1'b1;
               slot_bus.wr_slot = ccsu_pkg::SLOT_PDOWN;
               pdone_d          = 1'b1;
               state_d          = CCSU_DOWN;
            end else if (cmd_valid) begin
               case (cmd_code)
                  ccsu_pkg::CMD_SAVE: begin
                     if (cmd_arg[7:5] == 3'h0 && cmd_arg[4:0] <= ccsu_pkg::SLOT_MAX) begin
                        slot_bus.wr_en   = 1'b1;
                        slot_bus.wr_slot = cmd_arg[4:0];
                     end else begin
                        err_push(ccsu_pkg::ERR_RANGE);
                     end
                  end
                  ccsu_pkg::CMD_RECALL: begin
                     if (cmd_arg[7:5] == 3'h0 && cmd_arg[4:0] <= ccsu_pkg::SLOT_MAX) begin
                        rslot_d = cmd_arg[4:0];
                        state_d = CCSU_BOOT_RD;
                     end else begin
                        err_push(ccsu_pkg::ERR_RANGE);
                     end
                  end
                  ccsu_pkg::CMD_SRE_WR: begin
                     sre_d = cmd_arg;
                  end
                  ccsu_pkg::CMD_SRE_RD: begin
                     ans_d  = {8'h00, sre_q};
                     ansv_d = 1'b1;
                  end
                  ccsu_pkg::CMD_STB_RD: begin
                     ans_d  = {8'h00, stb_q};
                     ansv_d = 1'b1;
                  end
                  ccsu_pkg::CMD_CLS: begin
                     ecnt_d = 5'h00;
                     eovf_d = 1'b0;
                  end
                  ccsu_pkg::CMD_RST: begin
                     factory_reset();
                  end
                  ccsu_pkg::CMD_INIT: begin
                     wtrig_d = trig_src_bus;
                  end
                  ccsu_pkg::CMD_TRG: begin
                     if (wtrig_q) begin
                        trg_d   = 1'b1;
                        wtrig_d = 1'b0;
                     end else begin
                        err_push(ccsu_pkg::ERR_TRG_IGN);
                     end
                  end
                  ccsu_pkg::CMD_TST: begin
                     tcnt_d  = 32'h0;
                     state_d = CCSU_TEST;
                  end
                  ccsu_pkg::CMD_WAI: begin
                     state_d = CCSU_WAIT;
                  end
                  ccsu_pkg::CMD_ERR_RD: begin
                     ansv_d = 1'b1;
                     if (ecnt_q == 5'h00) begin
                        ans_d = ccsu_pkg::ERR_NONE;
                     end else begin
                        ans_d = errq_q[0];
                        for (int i = 0; i < ccsu_pkg::ERRQ_DEPTH - 1; i++) begin
                           errq_d[i] = errq_q[i+1];
                        end
                        ecnt_d = ecnt_q - 5'h01;
                        eovf_d = 1'b0;
                     end
                  end
                  ccsu_pkg::CMD_PSC_WR: begin
                     psc_d     = cmd_arg[0];
                     pwr_rst_d = cmd_arg[1];
                  end
                  default: begin
                     // Presets change nothing held here
                  end
               endcase
            end
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Status byte and service request
   // ------------------------------------------------------------------
   always_comb begin
      stb_d = ccsu_pkg::STB_RESET;
      if (!stb_clr_d) begin
         stb_d[ccsu_pkg::STB_ERRQ] = (ecnt_d != 5'h00);
         stb_d[ccsu_pkg::STB_QUES] = sync2_q[4];
         stb_d[ccsu_pkg::STB_MAV]  = sync2_q[3];
         stb_d[ccsu_pkg::STB_ESB]  = sync2_q[2];
         stb_d[ccsu_pkg::STB_OPER] = sync2_q[1];
      end
      srq_d = |(stb_d & sre_d);
   end

   // Register stage; the power-on mask value is always SRE_RESET, since rstn sets psc_q
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q   <= CCSU_BOOT;
         sre_q     <= ccsu_pkg::SRE_RESET;
         psc_q     <= 1'b1;
         pwr_rst_q <= 1'b0;
         stb_clr_q <= 1'b0;
         stb_q     <= ccsu_pkg::STB_RESET;
         srq_q     <= 1'b0;
         wtrig_q   <= 1'b0;
         trg_q     <= 1'b0;
         tcnt_q    <= 32'h0;
         rslot_q   <= ccsu_pkg::SLOT_PDOWN;
         ans_q     <= 16'h0000;
         ansv_q    <= 1'b0;
         cfgl_q    <= ccsu_pkg::CFG_FACTORY;
         cfglv_q   <= 1'b0;
         pdone_q   <= 1'b0;
         ecnt_q    <= 5'h00;
         eovf_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         sre_q     <= (state_q == CCSU_BOOT && psc_q) ? ccsu_pkg::SRE_RESET : sre_d;
         psc_q     <= psc_d;
         pwr_rst_q <= pwr_rst_d;
         stb_clr_q <= stb_clr_d;
         stb_q     <= stb_d;
         srq_q     <= srq_d;
         wtrig_q   <= wtrig_d;
         trg_q     <= trg_d;
         tcnt_q    <= tcnt_d;
         rslot_q   <= rslot_d;
         ans_q     <= ans_d;
         ansv_q    <= ansv_d;
         cfgl_q    <= cfgl_d;
         cfglv_q   <= cfglv_d;
         pdone_q   <= pdone_d;
         ecnt_q    <= ecnt_d;
         eovf_q    <= eovf_d;
      end
   end

   // Queue storage is data only; the count defines validity
   always_ff @(posedge clk) begin
      errq_q <= errq_d;
   end

   // Ready is registered; low while busy so the parser stalls
   logic rdy_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdy_q <= 1'b0;
      end else begin
         rdy_q <= (state_d == CCSU_IDLE);
      end
   end

   assign cmd_ready      = rdy_q;
   assign cfg_load       = cfgl_q;
   assign cfg_load_valid = cfglv_q;
   assign ans_data       = ans_q;
   assign ans_valid      = ansv_q;
   assign srq            = srq_q;
   assign trig_out       = trg_q;
   assign wait_trig      = wtrig_q;

endmodule : ccsu_top

//--- testbench/ccsu_asserts.sv
// Port-level assertions for the command and status unit.
// Assumes it is bound onto ccsu_top and sees only that module's ports.
`timescale 1ns/1ns
module ccsu_asserts #(
   parameter int unsigned SELFTEST_CYCLES = 8
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        cmd_valid,
   input wire logic [3:0]  cmd_code,
   input wire logic [7:0]  cmd_arg,
   input wire logic        cmd_ready,
   input wire logic [15:0] ans_data,
   input wire logic        ans_valid,
   input wire logic        srq,
   input wire logic        trig_out,
   input wire logic        wait_trig
);
   localparam int TLAT = SELFTEST_CYCLES + 1;
   logic       tk;
   logic [7:0] msk_d;
   logic [7:0] msk_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   assign tk = cmd_valid && cmd_ready;
   // Mirror of the enable mask; presets and clears must not move it
   always_comb begin
      msk_d = msk_q;
      if (tk && cmd_code == ccsu_pkg::CMD_SRE_WR) msk_d = cmd_arg;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) msk_q <= 8'h00;
      else msk_q <= msk_d;
   end
   property p_sre; tk && cmd_code == ccsu_pkg::CMD_SRE_RD |=> ans_valid && ans_data == {8'h00, msk_q}; endproperty
   a_sre: assert property (p_sre) else $error("mask readback wrong");
   property p_stb; tk && cmd_code == ccsu_pkg::CMD_STB_RD |=> ans_valid && ans_data[1:0] == 2'h0 && !ans_data[6]
      && ans_data[15:8] == 8'h00; endproperty
   a_stb: assert property (p_stb) else $error("status byte layout wrong");
   property p_trg; tk && cmd_code == ccsu_pkg::CMD_TRG && wait_trig |=> trig_out; endproperty
   a_trg: assert property (p_trg) else $error("trigger not accepted");
   property p_ign; tk && cmd_code == ccsu_pkg::CMD_TRG && !wait_trig |=> !trig_out; endproperty
   a_ign: assert property (p_ign) else $error("trigger taken while not armed");
   property p_trv; trig_out |-> $past(wait_trig); endproperty
   a_trv: assert property (p_trv) else $error("trigger pulse without arming");
   property p_tst; tk && cmd_code == ccsu_pkg::CMD_TST |-> ##TLAT ans_valid
      && (ans_data == ccsu_pkg::ANS_PASS || ans_data == ccsu_pkg::ANS_FAIL); endproperty
   a_tst: assert property (p_tst) else $error("self-test answer late or bad");
   property p_busy; tk && cmd_code == ccsu_pkg::CMD_TST |=> ##1 !cmd_ready [*4]; endproperty
   a_busy: assert property (p_busy) else $error("ready during self-test");
   // Mask path is one register deep, allow two cycles of lag
   property p_srq; srq |-> msk_q != 8'h00 || $past(msk_q) != 8'h00 || $past(msk_q, 2) != 8'h00; endproperty
   a_srq: assert property (p_srq) else $error("service request with empty mask");
   c_trg: cover property (trig_out);
   c_fail: cover property (ans_valid && ans_data == ccsu_pkg::ANS_FAIL);
   c_srq: cover property (srq);
endmodule : ccsu_asserts
bind ccsu_top ccsu_asserts #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) u_ccsu_asserts (.clk(clk), .rstn(rstn),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .ans_data(ans_data),
   .ans_valid(ans_valid), .srq(srq), .trig_out(trig_out), .wait_trig(wait_trig));

//--- testbench/ccsu_host_model.sv
// Remote host model: issues one command at a time on the command port.
// Assumes a single clock; drives only at falling edges.
`timescale 1ns/1ns
module ccsu_host_model (
   input wire logic        clk,
   input wire logic        cmd_ready,
   input wire logic        ans_valid,
   input wire logic [15:0] ans_data,
   output logic            cmd_valid,
   output logic [3:0]      cmd_code,
   output logic [7:0]      cmd_arg
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      cmd_arg = 8'h00;
   end
   // Two idle cycles first; ready is already low from the edge that takes a long command
   task automatic cmd(input logic [3:0] c, input logic [7:0] a, input bit q, output logic [15:0] d, output bit ok);
      int n;
      repeat (2) @(negedge clk);
      for (n = 0; n < 80 && cmd_ready !== 1'b1; n++) @(negedge clk);
      ok = (n < 80);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_arg = a;
      @(negedge clk);
      cmd_valid = 1'b0;
      // Released lines carry garbage, never the last value
      cmd_code = ~c;
      cmd_arg = ~a;
      for (n = 0; q && n < 80 && ans_valid !== 1'b1; n++) @(negedge clk);
      if (q) ok = ok && (n < 80);
      d = ans_data;
   endtask : cmd
endmodule : ccsu_host_model

//--- testbench/ccsu_top_tb.sv
// Self-checking bench for the command and status unit.
// Assumes the host model drives commands; conditions come from here.
`timescale 1ns/1ns
module ccsu_top_tb;
   logic clk = 0, rstn = 0, pd = 0, mc = 0, qc = 0, ec = 0, oc = 0, opp = 0, tsb = 0, stf = 0;
   logic [31:0] cfg = 32'h0, cfg_load;
   logic [15:0] ans_data, d;
   logic [7:0]  cmd_arg, mv [3] = '{8'hff, 8'h00, 8'h14};
   logic [3:0]  cmd_code, ks [4] = '{ccsu_pkg::CMD_CLS, ccsu_pkg::CMD_RST, ccsu_pkg::CMD_SYS_PRE, ccsu_pkg::CMD_STAT_PRE};
   logic        cmd_valid, cmd_ready, ans_valid, srq, trig_out, wait_trig, clv;
   bit          ok;
   int          err_count = 0, comparisons = 0, i;
   initial forever #2 clk = ~clk;
   ccsu_top #(.SELFTEST_CYCLES(8)) u_ccsu_top (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .cfg_live(cfg), .cfg_load(cfg_load), .cfg_load_valid(clv),
      .power_down(pd), .ques_cond(qc), .mav_cond(mc), .esb_cond(ec), .oper_cond(oc), .ops_pending(opp),
      .trig_src_bus(tsb), .selftest_fail(stf), .ans_data(ans_data), .ans_valid(ans_valid), .srq(srq),
      .trig_out(trig_out), .wait_trig(wait_trig));
   ccsu_host_model u_ccsu_host_model (.clk(clk), .cmd_ready(cmd_ready), .ans_valid(ans_valid),
      .ans_data(ans_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg));
   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Command with or without an answer; a timeout ends the run
   task automatic c(input logic [3:0] k, input logic [7:0] a, input bit q = 0);
      u_ccsu_host_model.cmd(k, a, q, d, ok);
      if (!ok) begin
         err_count++;
         stop_test();
      end
   endtask : c
   task automatic qr(input logic [3:0] k, input string n, input logic [31:0] e);
      c(k, 8'h00, 1);
      chk(n, d, e);
   endtask : qr
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1;
      // Mask load and readback, then commands that must leave it alone
      foreach (mv[j]) begin
         c(ccsu_pkg::CMD_SRE_WR, mv[j]);
         qr(ccsu_pkg::CMD_SRE_RD, "mask", {24'h0, mv[j]});
      end
      foreach (ks[j]) begin
         c(ks[j], 8'h00);
         qr(ccsu_pkg::CMD_SRE_RD, "mask", 32'h14);
      end
      mc = 1;
      repeat (6) @(negedge clk);
      chk("srq", srq, 1);
      for (i = 0; i < 2; i++) qr(ccsu_pkg::CMD_STB_RD, "stb", 32'h10);
      c(ccsu_pkg::CMD_SRE_WR, 8'h08);
      repeat (6) @(negedge clk);
      chk("srq", srq, 0);
      mc = 0;
      c(ccsu_pkg::CMD_TRG, 8'h00);
      qr(ccsu_pkg::CMD_STB_RD, "stb", 32'h04);
      qr(ccsu_pkg::CMD_ERR_RD, "err", 32'hff2d);
      tsb = 1;
      c(ccsu_pkg::CMD_INIT, 8'h00);
      repeat (2) @(negedge clk);
      chk("armed", wait_trig, 1);
      c(ccsu_pkg::CMD_TRG, 8'h00);
      qr(ccsu_pkg::CMD_ERR_RD, "err", 32'h0);
      c(ccsu_pkg::CMD_INIT, 8'h00);
      stf = 1;
      qr(ccsu_pkg::CMD_TST, "tst", 32'h1);
      qr(ccsu_pkg::CMD_ERR_RD, "err", 32'h276);
      chk("armed", wait_trig, 0);
      stf = 0;
      qr(ccsu_pkg::CMD_TST, "tst", 32'h0);
      cfg = 32'h1234_5678;
      c(ccsu_pkg::CMD_SAVE, 8'h10);
      cfg = 32'h0bad_f00d;
      c(ccsu_pkg::CMD_SAVE, 8'h10);
      qr(ccsu_pkg::CMD_ERR_RD, "err", 32'h0);
      c(ccsu_pkg::CMD_RST, 8'h00);
      c(ccsu_pkg::CMD_RECALL, 8'h10);
      @(negedge clk);
      chk("load", clv, 0);
      @(negedge clk);
      chk("load", clv, 1);
      chk("cfg", cfg_load, 32'h0bad_f00d);
      c(ccsu_pkg::CMD_RECALL, 8'h05);
      qr(ccsu_pkg::CMD_ERR_RD, "err", 32'hff1f);
      // Slot 17 is out of range: 21 errors overflow the queue
      for (i = 0; i < 21; i++) c(ccsu_pkg::CMD_SAVE, 8'h11);
      for (i = 0; i < 21; i++) qr(ccsu_pkg::CMD_ERR_RD, "errq", i == 19 ? 32'hfea2 : i == 20 ? 0 : 32'hff22);
      c(ccsu_pkg::CMD_SAVE, 8'h11);
      c(ccsu_pkg::CMD_CLS, 8'h00);
      qr(ccsu_pkg::CMD_ERR_RD, "err", 32'h0);
      opp = 1;
      c(ccsu_pkg::CMD_WAI, 8'h00);
      repeat (10) @(negedge clk);
      chk("ready", cmd_ready, 0);
      opp = 0;
      qr(ccsu_pkg::CMD_SRE_RD, "mask", 32'h08);
      // Power-down save, then a power cycle restores it
      cfg = 32'h00c0_ffee;
      pd = 1;
      repeat (10) @(negedge clk);
      rstn = 0;
      pd = 0;
      repeat (12) @(negedge clk);
      rstn = 1;
      repeat (8) @(negedge clk);
      chk("cfg", cfg_load, 32'h00c0_ffee);
      qr(ccsu_pkg::CMD_SRE_RD, "mask", 32'h0);
      qr(ccsu_pkg::CMD_STB_RD, "stb", 32'h0);
      stop_test();
   end
endmodule : ccsu_top_tb
